// ---- verilog/aal_top.sv ----
// Accumulator ALU operations with APB status and control registers
//
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/1ps
module aal_top #(
	parameter int DATA_W = aal_pkg::AAL_DW
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Core request
	input wire aal_pkg::aal_req_t req,
	// Prefix load from core
	input wire logic pfx_load,
	input wire logic [7:0] pfx_data,
	// Core answer
	output aal_pkg::aal_rsp_t rsp
);
	import aal_pkg::*;

	if (DATA_W != AAL_DW) begin : g_chk
		$error("aal_top: DATA_W must be 16");
	end

	//////////////////////////////////////////////////////////////////////
	// State

	logic en_r;
	aal_flags_t flags_r;
	aal_flags_t flags_nxt;
	logic [7:0] pfx_r;
	logic [7:0] pfx_nxt;
	logic pfx_vld_r;
	logic pfx_vld_nxt;
	logic [15:0] last_r;
	logic [31:0] cnt_r;
	logic [31:0] cnt_nxt;
	logic err_src_r;
	logic err_unk_r;
	aal_rsp_t rsp_r;
	aal_rsp_t rsp_nxt;

	//////////////////////////////////////////////////////////////////////
	// Decode

	aal_op_t op;
	logic fmt_reg;
	logic src_op;

	aal_decode i_aal_decode (
		.opcode(req.opcode),
		.op(op),
		.fmt_reg(fmt_reg),
		.src_op(src_op)
	);

	//////////////////////////////////////////////////////////////////////
	// Operand selection

	wire logic [7:0] hi_byte_def = fmt_reg ? req.src[15:8] : AAL_BYTE_RST;
	wire logic byte_src = !fmt_reg || !req.src_wide;
	wire logic [7:0] hi_byte = (byte_src && pfx_vld_r) ? pfx_r : hi_byte_def;
	wire logic [7:0] lo_byte = fmt_reg ? req.src[7:0] : req.opcode[7:0];
	wire logic [15:0] operand = (fmt_reg && req.src_wide) ? req.src :
		{hi_byte, lo_byte};

	//////////////////////////////////////////////////////////////////////
	// Execute

	aal_exec_t ex;

	aal_exec i_aal_exec (
		.op(op),
		.acc(req.acc),
		.src(operand),
		.flags_in(flags_r),
		.res(ex)
	);

	wire logic is_ours = op != AAL_OP_NONE;
	wire logic bad_src = src_op && fmt_reg && req.src_is_acc;
	wire logic take = req.valid && en_r;
	wire logic exec_ok = take && is_ours && !bad_src;
	wire logic unk_hit = take && !is_ours;
	wire logic src_hit = take && is_ours && bad_src;

	//////////////////////////////////////////////////////////////////////
	// APB decode

	wire logic apb_acc = psel && penable;
	wire logic apb_wr = apb_acc && pwrite;
	wire logic sel_ctrl = paddr == AAL_OFS_CTRL;
	wire logic sel_flags = paddr == AAL_OFS_FLAGS;
	wire logic sel_pfx = paddr == AAL_OFS_PFX;
	wire logic sel_res = paddr == AAL_OFS_RESULT;
	wire logic sel_cnt = paddr == AAL_OFS_COUNT;
	wire logic sel_err = paddr == AAL_OFS_ERR;
	wire logic mapped = sel_ctrl | sel_flags | sel_pfx | sel_res | sel_cnt |
		sel_err;
	wire logic wr_ctrl = apb_wr && sel_ctrl;
	wire logic wr_flags = apb_wr && sel_flags;
	wire logic wr_pfx = apb_wr && sel_pfx;
	wire logic wr_err = apb_wr && sel_err;
	wire logic cnt_clr = wr_ctrl && pwdata[AAL_CTL_CNTCLR];

	assign pready = 1'b1;
	assign pslverr = apb_acc && !mapped;

	wire logic [31:0] rd_ctrl = {31'h0, en_r};
	wire logic [31:0] rd_flags = {28'h0, flags_r.ov, flags_r.z, flags_r.s,
		flags_r.c};
	wire logic [31:0] rd_pfx = {23'h0, pfx_vld_r, pfx_r};
	wire logic [31:0] rd_res = {16'h0, last_r};
	wire logic [31:0] rd_err = {30'h0, err_unk_r, err_src_r};
	wire logic [31:0] rd_mux = sel_ctrl ? rd_ctrl :
		sel_flags ? rd_flags :
		sel_pfx ? rd_pfx :
		sel_res ? rd_res :
		sel_cnt ? cnt_r :
		sel_err ? rd_err : 32'h0000_0000;

	assign prdata = (psel && !pwrite) ? rd_mux : 32'h0000_0000;

	//////////////////////////////////////////////////////////////////////
	// Next values

	wire aal_flags_t flags_sw = '{ov: pwdata[AAL_FLG_OV], z: pwdata[AAL_FLG_Z],
		s: pwdata[AAL_FLG_S], c: pwdata[AAL_FLG_C]};
	assign flags_nxt = exec_ok ? ex.flags : (wr_flags ? flags_sw : flags_r);

	assign pfx_vld_nxt = pfx_load ? 1'b1 :
		wr_pfx ? pwdata[AAL_PFX_VLD] :
		take ? 1'b0 : pfx_vld_r;
	assign pfx_nxt = pfx_load ? pfx_data :
		wr_pfx ? pwdata[7:0] : pfx_r;

	assign cnt_nxt = cnt_clr ? AAL_CNT_RST :
		exec_ok ? cnt_r + 32'h0000_0001 : cnt_r;

	assign rsp_nxt.done = take;
	assign rsp_nxt.wr = exec_ok;
	assign rsp_nxt.err = take && (!is_ours || bad_src);
	assign rsp_nxt.result = exec_ok ? ex.result : rsp_r.result;
	assign rsp_nxt.flags = flags_nxt;

	assign rsp = rsp_r;

	//////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			en_r <= AAL_EN_RST;
		end else if (wr_ctrl) begin
			en_r <= pwdata[AAL_CTL_EN];
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			flags_r <= '0;
			pfx_r <= AAL_BYTE_RST;
			pfx_vld_r <= 1'b0;
			cnt_r <= AAL_CNT_RST;
		end else begin
			flags_r <= flags_nxt;
			pfx_r <= pfx_nxt;
			pfx_vld_r <= pfx_vld_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			last_r <= AAL_WORD_RST;
		end else if (exec_ok) begin
			last_r <= ex.result;
		end
	end

	// Sticky errors, set wins over clear
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			err_src_r <= 1'b0;
			err_unk_r <= 1'b0;
		end else begin
			err_src_r <= src_hit | (err_src_r & !(wr_err & pwdata[AAL_ERR_SRC]));
			err_unk_r <= unk_hit | (err_unk_r & !(wr_err & pwdata[AAL_ERR_UNK]));
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rsp_r <= '0;
		end else begin
			rsp_r <= rsp_nxt;
		end
	end

endmodule : aal_top

// ---- verilog/aal_pkg.sv ----
// Constants and types for the accumulator ALU operations block
package aal_pkg;

	localparam int AAL_DW = 16;

	// Fixed opcodes and keyed opcode fields
	localparam logic [15:0] AAL_OPC_SHR4 = 16'h8ABA;
	localparam logic [15:0] AAL_OPC_XBYTE = 16'h8A8A;
	localparam logic [15:0] AAL_OPC_XNIB = 16'h8A7A;
	localparam logic [6:0] AAL_KEY_SUB = 7'h5A;
	localparam logic [6:0] AAL_KEY_SUBTRACT_WITH_BORROW_OP = 7'h7A;
	localparam logic [6:0] AAL_KEY_XOR = 7'h3A;
	localparam int AAL_FMT_BIT = 15;
	localparam int AAL_KEY_HI = 14;
	localparam int AAL_KEY_LO = 8;
	localparam int AAL_SHIFT = 4;

	// Register byte offsets
	localparam logic [11:0] AAL_OFS_CTRL = 12'h000;
	localparam logic [11:0] AAL_OFS_FLAGS = 12'h004;
	localparam logic [11:0] AAL_OFS_PFX = 12'h008;
	localparam logic [11:0] AAL_OFS_RESULT = 12'h00C;
	localparam logic [11:0] AAL_OFS_COUNT = 12'h010;
	localparam logic [11:0] AAL_OFS_ERR = 12'h014;

	// Field positions
	localparam int AAL_CTL_EN = 0;
	localparam int AAL_CTL_CNTCLR = 1;
	localparam int AAL_FLG_C = 0;
	localparam int AAL_FLG_S = 1;
	localparam int AAL_FLG_Z = 2;
	localparam int AAL_FLG_OV = 3;
	localparam int AAL_PFX_VLD = 8;
	localparam int AAL_ERR_SRC = 0;
	localparam int AAL_ERR_UNK = 1;

	// Reset values
	localparam logic AAL_EN_RST = 1'b1;
	localparam logic [15:0] AAL_WORD_RST = 16'h0000;
	localparam logic [7:0] AAL_BYTE_RST = 8'h00;
	localparam logic [31:0] AAL_CNT_RST = 32'h0000_0000;

	typedef enum logic [2:0] {
		AAL_OP_NONE,
		AAL_OP_SHR4,
		AAL_OP_SUB,
		AAL_OP_SUBTRACT_WITH_BORROW_OP,
		AAL_OP_XBYTE,
		AAL_OP_XNIB,
		AAL_OP_XOR
	} aal_op_t;

	typedef struct packed {
		logic ov;
		logic z;
		logic s;
		logic c;
	} aal_flags_t;

	typedef struct packed {
		logic valid;
		logic [15:0] opcode;
		logic [15:0] acc;
		logic [15:0] src;
		logic src_wide;
		logic src_is_acc;
	} aal_req_t;

	typedef struct packed {
		logic done;
		logic wr;
		logic err;
		logic [15:0] result;
		aal_flags_t flags;
	} aal_rsp_t;

	typedef struct packed {
		logic [15:0] result;
		aal_flags_t flags;
	} aal_exec_t;

endpackage : aal_pkg

// ---- verilog/aal_decode.sv ----
// Opcode decoder for the accumulator ALU operations
`timescale 1ns/1ps
module aal_decode (
	// Instruction word
	input wire logic [15:0] opcode,
	// Decoded operation
	output aal_pkg::aal_op_t op,
	output logic fmt_reg,
	output logic src_op
);
	import aal_pkg::*;

	wire logic [6:0] key = opcode[AAL_KEY_HI:AAL_KEY_LO];
	wire logic hit_shr4 = opcode == AAL_OPC_SHR4;
	wire logic hit_xbyte = opcode == AAL_OPC_XBYTE;
	wire logic hit_xnib = opcode == AAL_OPC_XNIB;
	wire logic hit_sub = key == AAL_KEY_SUB;
	wire logic hit_subtract_with_borrow_op = key == AAL_KEY_SUBTRACT_WITH_BORROW_OP;
	wire logic hit_xor = key == AAL_KEY_XOR;

	assign op = hit_shr4 ? AAL_OP_SHR4 :
		hit_xbyte ? AAL_OP_XBYTE :
		hit_xnib ? AAL_OP_XNIB :
		hit_sub ? AAL_OP_SUB :
		hit_subtract_with_borrow_op ? AAL_OP_SUBTRACT_WITH_BORROW_OP :
		hit_xor ? AAL_OP_XOR : AAL_OP_NONE;
	assign fmt_reg = opcode[AAL_FMT_BIT];
	assign src_op = hit_sub | hit_subtract_with_borrow_op | hit_xor;

endmodule : aal_decode

// ---- verilog/aal_exec.sv ----
// Result and flag computation for the accumulator ALU operations
`timescale 1ns/1ps
module aal_exec (
	// Operation and operands
	input wire aal_pkg::aal_op_t op,
	input wire logic [15:0] acc,
	input wire logic [15:0] src,
	input wire aal_pkg::aal_flags_t flags_in,
	// Result
	output aal_pkg::aal_exec_t res
);
	import aal_pkg::*;

	function automatic logic is_zero(input logic [15:0] v);
		is_zero = v == AAL_WORD_RST;
	endfunction : is_zero

	wire logic is_sub = op == AAL_OP_SUB || op == AAL_OP_SUBTRACT_WITH_BORROW_OP;
	wire logic borrow_in = op == AAL_OP_SUBTRACT_WITH_BORROW_OP && flags_in.c;
	wire logic [16:0] diff = {1'b0, acc} - {1'b0, src} - {16'h0000, borrow_in};
	wire logic [15:0] shr4 = {{AAL_SHIFT{acc[15]}}, acc[15:AAL_SHIFT]};
	wire logic [15:0] xbyte = {acc[7:0], acc[15:8]};
	wire logic [15:0] xnib = {acc[11:8], acc[15:12], acc[3:0], acc[7:4]};
	wire logic [15:0] xval = acc ^ src;
	wire logic [15:0] r = is_sub ? diff[15:0] :
		op == AAL_OP_SHR4 ? shr4 :
		op == AAL_OP_XBYTE ? xbyte :
		op == AAL_OP_XNIB ? xnib :
		op == AAL_OP_XOR ? xval : acc;
	wire logic ov_sub = (acc[15] != src[15]) && (r[15] != acc[15]);
	wire logic c_new = is_sub ? diff[16] :
		op == AAL_OP_SHR4 ? acc[AAL_SHIFT - 1] : flags_in.c;
	wire logic upd_s = op != AAL_OP_SHR4 && op != AAL_OP_NONE;
	wire logic upd_z = is_sub || op == AAL_OP_XOR || op == AAL_OP_SHR4;

	assign res.result = r;
	assign res.flags.c = c_new;
	assign res.flags.s = upd_s ? r[15] : flags_in.s;
	assign res.flags.z = upd_z ? is_zero(r) : flags_in.z;
	assign res.flags.ov = is_sub ? ov_sub : flags_in.ov;

endmodule : aal_exec

// ---- test/aal_top_properties.sv ----
// Checker for the accumulator ALU operations block
`timescale 1ns/1ps
module aal_top_properties import aal_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Core side
	input wire aal_pkg::aal_req_t req,
	input wire logic pfx_load,
	input wire logic [7:0] pfx_data,
	input wire aal_pkg::aal_rsp_t rsp
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	logic [15:0] acc_r;
	logic [15:0] src_r;
	wire [6:0] key = req.opcode[14:8];
	wire keyed = key == AAL_KEY_SUB || key == AAL_KEY_SUBTRACT_WITH_BORROW_OP
		|| key == AAL_KEY_XOR;
	wire wide = req.valid & req.opcode[15] & req.src_wide & !req.src_is_acc;
	wire bad = req.valid & req.opcode[15] & req.src_is_acc & keyed;
	always_ff @(posedge clk) begin
		acc_r <= req.acc;
		src_r <= req.src;
	end
	////////////////////////////////////////////////////////////////////////
	a_done_cause: assert property (rsp.done |-> $past(req.valid))
		else $error("done without request");
	a_shift_four: assert property (
		req.valid && req.opcode == AAL_OPC_SHR4 |=>
		!rsp.done || rsp.result == {{4{acc_r[15]}}, acc_r[15:4]}
		&& rsp.flags.c == acc_r[3])
		else $error("shift result wrong");
	a_byte_swap: assert property (
		req.valid && req.opcode == AAL_OPC_XBYTE |=>
		!rsp.done || rsp.result == {acc_r[7:0], acc_r[15:8]}
		&& rsp.flags.s == acc_r[7])
		else $error("byte swap wrong");
	a_nib_swap: assert property (
		req.valid && req.opcode == AAL_OPC_XNIB |=>
		!rsp.done || rsp.result == {acc_r[11:8], acc_r[15:12], acc_r[3:0],
		acc_r[7:4]})
		else $error("nibble swap wrong");
	a_swap_keep: assert property (
		req.valid && (req.opcode == AAL_OPC_XNIB
		|| req.opcode == AAL_OPC_XBYTE) |=> !rsp.done || $stable(rsp.flags.c)
		&& $stable(rsp.flags.z) && $stable(rsp.flags.ov))
		else $error("swap touched flags");
	a_sub_wide: assert property (
		wide && key == AAL_KEY_SUB |=> !rsp.done
		|| rsp.result == acc_r - src_r && rsp.flags.z == (acc_r == src_r))
		else $error("subtract wrong");
	a_xor_wide: assert property (
		wide && key == AAL_KEY_XOR |=> !rsp.done
		|| rsp.result == (acc_r ^ src_r))
		else $error("xor wrong");
	a_acc_src: assert property (
		bad && !(psel && penable && pwrite && paddr == AAL_OFS_FLAGS)
		|=> !rsp.done || rsp.err && !rsp.wr && $stable(rsp.flags))
		else $error("accumulator source accepted");
	a_apb_unmapped: assert property (psel && penable && paddr > 12'h014 |->
		pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
endmodule : aal_top_properties

bind aal_top aal_top_properties i_aal_top_properties (.clk(clk),
	.rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .req(req), .pfx_load(pfx_load),
	.pfx_data(pfx_data), .rsp(rsp));

// ---- test/aal_top_tb.sv ----
// Self-checking testbench for the accumulator ALU operations block
`timescale 1ns/1ps
module aal_top_tb;
	import aal_pkg::*;
	logic clk, rst_b, psel, penable, pwrite, pready, pslverr, pfx_load;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rn, sv;
	logic [7:0] pfx_data, pb;
	logic pv, en;
	logic [1:0] ev = 2'b00;
	int nx = 0;
	logic [15:0] last, o;
	aal_req_t req;
	aal_rsp_t rsp;
	aal_flags_t f;
	logic [32:0] rq[$];
	logic [21:0] q[$];
	int mismatches, num_checks, j;
	int seed = 32'h1D66D4B0;
	logic [15:0] tbl[6] = '{AAL_OPC_SHR4, AAL_OPC_XBYTE, AAL_OPC_XNIB,
		16'h5A00, 16'h7A00, 16'h3A00};
	aal_top i_aal_top (.clk(clk), .rst_b(rst_b), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .req(req),
		.pfx_load(pfx_load), .pfx_data(pfx_data), .rsp(rsp));
	initial begin
		clk = 0;
		forever #20 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [39:0] g, e);
		num_checks++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up
	task automatic apb(input logic [11:0] a, input logic w, logic [31:0] d);
		@(posedge clk);
		{psel, paddr, pwrite, pwdata} <= {1'b1, a, w, d};
		if (!w) rq.push_back({!(a inside {AAL_OFS_CTRL, AAL_OFS_FLAGS,
			AAL_OFS_PFX, AAL_OFS_RESULT, AAL_OFS_COUNT, AAL_OFS_ERR}), d});
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		{psel, penable} <= 2'b00;
	endtask : apb
	task automatic idle;
		@(posedge clk);
		req.valid <= 0;
	endtask : idle
	task automatic prefix_register(input logic [7:0] d);
		@(posedge clk);
		{pfx_load, pfx_data} <= {1'b1, d};
		@(posedge clk);
		pfx_load <= 0;
		{pv, pb} = {1'b1, d};
	endtask : prefix_register
	task automatic op(input logic [15:0] o, a, s, input logic w, ia);
		logic [15:0] b, r;
		logic [16:0] d;
		logic [6:0] k;
		logic e, bad;
		@(posedge clk);
		req <= {1'b1, o, a, s, w, ia};
		if (!en) return;
		k = o[14:8];
		b = o[15] ? (w ? s : {pv ? pb : s[15:8], s[7:0]})
			: {pv ? pb : 8'h00, o[7:0]};
		pv = 0;
		bad = o[15] & ia & (k == AAL_KEY_SUB || k == AAL_KEY_SUBTRACT_WITH_BORROW_OP
			|| k == AAL_KEY_XOR);
		e = 0;
		r = a;
		if (o == AAL_OPC_SHR4) begin
			r = {{4{a[15]}}, a[15:4]};
			{f.z, f.c} = {r == 16'h0000, a[3]};
		end else if (o == AAL_OPC_XBYTE || o == AAL_OPC_XNIB) begin
			r = o[7] ? {a[7:0], a[15:8]} : {a[11:8], a[15:12], a[3:0], a[7:4]};
			f.s = r[15];
		end else if (!bad && (k == AAL_KEY_SUB || k == AAL_KEY_SUBTRACT_WITH_BORROW_OP)) begin
			d = {1'b0, a} - {1'b0, b} - (k == AAL_KEY_SUBTRACT_WITH_BORROW_OP ? f.c : 1'b0);
			r = d[15:0];
			f = {(a[15] ^ b[15]) & (a[15] ^ r[15]), r == 16'h0000, r[15], d[16]};
		end else if (!bad && k == AAL_KEY_XOR) begin
			r = a ^ b;
			{f.z, f.s} = {r == 16'h0000, r[15]};
		end else begin
			e = 1;
			ev = ev | (bad ? 2'b01 : 2'b10);
		end
		q.push_back(e ? {2'b01, last, f} : {2'b10, r, f});
		if (!e) begin
			last = r;
			nx++;
		end
	endtask : op
	always @(posedge clk) begin
		if (psel && penable && pready && !pwrite)
			chk({pslverr, prdata}, rq.pop_front());
		if (rsp.done === 1'b1)
			chk({rsp.wr, rsp.err, rsp.result, rsp.flags}, q.pop_front());
	end
	initial begin
		repeat (4000) @(posedge clk);
		mismatches++;
		wrap_up;
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		{rst_b, psel, penable, pwrite, pfx_load, pfx_data, paddr, pwdata} = '0;
		{req, f, pv, pb, last, en} = 1;
		req = '0;
		f = '0;
		repeat (20) @(posedge clk);
		rst_b <= 1;
		apb(AAL_OFS_FLAGS, 0, 0);
		apb(AAL_OFS_CTRL, 0, 1);
		apb(12'h100, 0, 0);
		op(AAL_OPC_SHR4, 16'h9878, 0, 0, 0);
		op(AAL_OPC_SHR4, 16'hF987, 0, 0, 0);
		idle;
		apb(AAL_OFS_FLAGS, 1, 1);
		f = 4'h1;
		op(16'hFA00, 16'h2345, 16'h1250, 1, 0);
		op(16'hFA00, 16'h10F4, 16'h1250, 1, 0);
		op(AAL_OPC_XBYTE, 16'h2345, 0, 0, 0);
		op(AAL_OPC_XNIB, 16'h2345, 0, 0, 0);
		op(16'hBA00, 16'h2345, 16'h0F0F, 1, 0);
		op(16'hDA00, 16'h2345, 16'h0001, 1, 1);
		op(16'h0000, 16'h2345, 0, 0, 0);
		idle;
		prefix_register(8'hA5);
		op(16'h5A3C, 16'h2345, 0, 0, 0);
		op(16'h5A3C, 16'h2345, 0, 0, 0);
		idle;
		prefix_register(8'h81);
		op(16'hBA07, 16'h2345, 16'h1234, 0, 0);
		for (int i = 0; i < 60; i++) begin
			rn = $random(seed);
			sv = $random(seed);
			j = rn[31:28] % 6;
			o = j < 3 ? tbl[j] : tbl[j] | {rn[27], 7'h00, rn[7:0]};
			op(o, rn[23:8], sv[15:0], rn[26], 0);
		end
		idle;
		apb(AAL_OFS_PFX, 1, 32'h0000_01C3);
		{pv, pb} = {1'b1, 8'hC3};
		apb(AAL_OFS_PFX, 0, 32'h0000_01C3);
		op(16'h3A11, 16'h0000, 0, 0, 0);
		idle;
		apb(AAL_OFS_PFX, 0, 32'h0000_00C3);
		apb(AAL_OFS_CTRL, 1, 0);
		en = 0;
		op(AAL_OPC_XBYTE, 16'h1234, 0, 0, 0);
		idle;
		apb(AAL_OFS_CTRL, 1, 1);
		en = 1;
		apb(AAL_OFS_FLAGS, 0, {28'h0, f});
		apb(AAL_OFS_RESULT, 0, {16'h0, last});
		apb(AAL_OFS_COUNT, 0, nx);
		apb(AAL_OFS_ERR, 0, {30'h0, ev});
		apb(AAL_OFS_ERR, 1, 3);
		apb(AAL_OFS_CTRL, 1, 3);
		apb(AAL_OFS_ERR, 0, 0);
		apb(AAL_OFS_COUNT, 0, 0);
		repeat (2) @(posedge clk);
		chk(32'(q.size() + rq.size()), 0);
		wrap_up;
	end
endmodule : aal_top_tb
